/* File: frt_regs.vh */
// Register map, field positions, reset values and timing for the free-running timer
// Assumes a 4-bit word address and 16-bit register data on the register port
`ifndef FRT_REGS_VH
`define FRT_REGS_VH

// Register offsets (word addresses)
`define REG_CTL0        4'h0
`define REG_MODE        4'h1
`define REG_IOC2        4'h2
`define REG_OPT0        4'h3
`define REG_CHAN0       4'h4
`define REG_CHAN1       4'h5
`define REG_CHAN2       4'h6
`define REG_CHAN3       4'h7
`define REG_COUNT       4'h8
`define REG_IRQ_STAT    4'h9
`define REG_IRQ_MASK    4'hA
`define REG_CAP_EDGE    4'hB

// Field positions
`define CTL0_CE_BIT     7
`define MODE_LSB        0
`define MODE_MSB        2
`define IOC2_ETS_LSB    0
`define IOC2_ETS_MSB    1
`define IOC2_EES_LSB    2
`define IOC2_EES_MSB    3
`define OPT0_OVF_BIT    0
`define OPT0_CCS_LSB    4
`define OPT0_CCS_MSB    7
`define IRQ_WRAP_BIT    4

// Operating mode codes
`define MODE_FREE_RUN   3'b101
`define MODE_PWM_OUT    3'b100

// Capture edge codes, two bits per channel
`define EDGE_NONE       2'b00
`define EDGE_RISE       2'b01
`define EDGE_FALL       2'b10
`define EDGE_BOTH       2'b11

// Reset values and counter limits
`define RST_ZERO16      16'h0000
`define CNT_MAX         16'hFFFF
`define CNT_MIN         16'h0000

// Count clock divider: system clocks per count clock
`define COUNT_DIV       1

`endif

/* File: free_running_timer_capture_compare.v */
// Four-channel 16-bit free-running timer with capture/compare channels and one interrupt
// Assumes one system clock, a synchronous reset, and capture pins from outside this domain
//
// Summary of operation
// - Outside PWM mode, match interrupt comes on the count-up after equality.
// - In PWM mode, match interrupt comes in the cycle the counter becomes equal.
// - Mode field 101 selects free-running timer operation.
// - Writing 1 to the count enable bit starts the 16-bit counter, in mode 101 or 100 only.
// - Each channel is compare or capture, chosen by its own select bit.
// - Starting the counter in free-running mode inverts all four channel output pins.
// - A compare match raises the channel interrupt and toggles its output pin.
// - From FFFFH the next count-up wraps to 0000H, raises wrap interrupt, keeps counting.
// - The wrap also sets the wrap flag, which holds until software clears it.
// - Compare values written while counting take effect at once.
// - A valid capture edge latches the counter and raises the channel interrupt.
// - Event edge select is a two-bit field; trigger edge bits held 0 in free-running mode.
//
// Local design decisions: strobed register access and the placing of the registers.
`timescale 1ns/100ps
`include "frt_regs.vh"

module free_running_timer_capture_compare #(
    parameter COUNT_DIV = `COUNT_DIV
) (
    // Clock and reset
    input  wire        clk_sys_i,
    input  wire        srst_i,
    // Register port
    input  wire [3:0]  addr_i,
    input  wire [15:0] wdata_i,
    input  wire        wr_i,
    input  wire        rd_i,
    output reg  [15:0] rdata_o,
    // Pins
    input  wire [3:0]  chan_capture_pin_i,
    output reg  [3:0]  chan_output_pin_o,
    // Interrupt
    output reg         irq_o
);

    // Control and configuration
    reg         count_enable_bit_ff;
    reg  [2:0]  operating_mode_field_ff;
    reg  [1:0]  event_edge_sel_ff;
    reg  [1:0]  trigger_edge_sel_ff;
    reg  [3:0]  chan_function_select_ff;
    reg         wrap_flag_ff;
    reg  [7:0]  cap_edge_ff;
    reg  [4:0]  irq_stat_ff;
    reg  [4:0]  irq_mask_ff;
    reg  [15:0] count_ff;
    reg  [15:0] div_ff;
    reg  [15:0] chan_val_ff [0:3];

    // Capture pin synchronisers and filtered levels
    reg  [3:0]  cap_s1_ff;
    reg  [3:0]  cap_s2_ff;
    reg  [3:0]  cap_s3_ff;
    reg  [3:0]  cap_lvl_ff;

    wire        free_run;
    wire        pwm_mode;
    wire        counting;
    wire        tick;
    wire        start;
    wire        wrap;
    wire [15:0] nxt_count;
    wire [3:0]  chan_hit;
    wire [3:0]  cap_hit;
    wire [3:0]  cap_rise;
    wire [3:0]  cap_fall;
    wire [3:0]  cap_agree;
    wire [4:0]  irq_event;
    wire        wr_ctl0;
    wire        wr_mode;
    wire        wr_ioc2;
    wire        wr_opt0;
    wire        wr_edge;
    wire        wr_mask;
    wire        wr_stat;
    wire        ce_wdata;
    wire [3:0]  nxt_pins;
    wire [4:0]  nxt_irq_stat;
    wire        nxt_irq;
    wire        nxt_wrap_flag;
    reg  [15:0] nxt_rdata;

    // Divider end held at full width, so the compare never drops bits
    localparam [31:0] DIV_LAST = COUNT_DIV - 1;

    assign free_run = (operating_mode_field_ff == `MODE_FREE_RUN);
    assign pwm_mode = (operating_mode_field_ff == `MODE_PWM_OUT);
    assign counting = count_enable_bit_ff & (free_run | pwm_mode);
    // Divider gives one count clock; with COUNT_DIV of 1 every system clock counts
    assign tick     = counting & ({16'h0000, div_ff} == DIV_LAST);
    assign wr_ctl0  = wr_i & (addr_i == `REG_CTL0);
    assign wr_mode  = wr_i & (addr_i == `REG_MODE);
    assign wr_ioc2  = wr_i & (addr_i == `REG_IOC2);
    assign wr_opt0  = wr_i & (addr_i == `REG_OPT0);
    assign wr_edge  = wr_i & (addr_i == `REG_CAP_EDGE);
    assign wr_mask  = wr_i & (addr_i == `REG_IRQ_MASK);
    assign wr_stat  = wr_i & (addr_i == `REG_IRQ_STAT);
    assign ce_wdata = wdata_i[`CTL0_CE_BIT];
    assign start    = wr_ctl0 & ce_wdata & ~count_enable_bit_ff;
    assign wrap     = tick & (count_ff == `CNT_MAX);
    assign nxt_count = wrap ? `CNT_MIN : count_ff + 16'h0001;

    // Stable level only moves once the second and third stages agree
    assign cap_agree = ~(cap_s2_ff ^ cap_s3_ff);
    assign cap_rise  = cap_agree & cap_s3_ff & ~cap_lvl_ff;
    assign cap_fall  = cap_agree & ~cap_s3_ff & cap_lvl_ff;

    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_chan
            wire [15:0] val;
            wire [1:0]  esel;
            assign val  = chan_val_ff[g];
            assign esel = cap_edge_ff[2*g+1:2*g];
            // Capture only while counting, so a stopped counter never overwrites values
            assign cap_hit[g] = counting & chan_function_select_ff[g] &
                                ((cap_rise[g] & esel[0]) | (cap_fall[g] & esel[1]));
            // Early timing in PWM mode lines the interrupt up with the pin change
            assign chan_hit[g] = tick & ~chan_function_select_ff[g] &
                                 (pwm_mode ? (nxt_count == val)
                                           : (count_ff == val));
        end
    endgenerate

    assign irq_event = {wrap, chan_hit | cap_hit};
    // Write one to clear; an event in the same cycle still sets its bit
    assign nxt_irq_stat = (irq_stat_ff & ~({5{wr_stat}} & wdata_i[4:0])) | irq_event;
    assign nxt_irq      = |(irq_stat_ff & irq_mask_ff);
    // Only a written 0 clears the flag, and a wrap wins the tie
    assign nxt_wrap_flag = wrap | (wrap_flag_ff & ~(wr_opt0 & ~wdata_i[`OPT0_OVF_BIT]));
    // Start in free-running mode inverts all pins; a match at the start edge is impossible
    assign nxt_pins = (start & free_run) ? ~chan_output_pin_o
                                         : (chan_output_pin_o ^ chan_hit);

    // Counter; a stopped counter sits at zero, ready for a fresh start
    always @(posedge clk_sys_i) begin
        if (srst_i) begin
            count_ff <= `RST_ZERO16;
        end else if (!counting) begin
            count_ff <= `CNT_MIN;
        end else if (tick) begin
            count_ff <= nxt_count;
        end
    end

    // Count clock divider
    always @(posedge clk_sys_i) begin
        if (srst_i) begin
            div_ff <= `RST_ZERO16;
        end else if (!counting || tick) begin
            div_ff <= `RST_ZERO16;
        end else begin
            div_ff <= div_ff + 16'h0001;
        end
    end

    // Channel output pins
    always @(posedge clk_sys_i) begin
        if (srst_i) begin
            chan_output_pin_o <= 4'h0;
        end else begin
            chan_output_pin_o <= nxt_pins;
        end
    end

    // Capture pin synchronisers
    always @(posedge clk_sys_i) begin
        if (srst_i) begin
            cap_s1_ff  <= 4'h0;
            cap_s2_ff  <= 4'h0;
            cap_s3_ff  <= 4'h0;
            cap_lvl_ff <= 4'h0;
        end else begin
            cap_s1_ff  <= chan_capture_pin_i;
            cap_s2_ff  <= cap_s1_ff;
            cap_s3_ff  <= cap_s2_ff;
            cap_lvl_ff <= (cap_s2_ff & cap_s3_ff) | (cap_lvl_ff & (cap_s2_ff | cap_s3_ff));
        end
    end

    // Channel value registers; a capture beats a software write in the same cycle
    integer i;
    always @(posedge clk_sys_i) begin
        if (srst_i) begin
            for (i = 0; i < 4; i = i + 1) begin
                chan_val_ff[i] <= `RST_ZERO16;
            end
        end else begin
            for (i = 0; i < 4; i = i + 1) begin
                if (cap_hit[i]) begin
                    chan_val_ff[i] <= count_ff;
                end else if (wr_i && (addr_i == (`REG_CHAN0 + i[3:0]))) begin
                    chan_val_ff[i] <= wdata_i;
                end
            end
        end
    end

    // Enable, mode, edge selects and channel functions
    always @(posedge clk_sys_i) begin
        if (srst_i) begin
            count_enable_bit_ff     <= 1'b0;
            operating_mode_field_ff <= 3'h0;
            event_edge_sel_ff       <= 2'h0;
            trigger_edge_sel_ff     <= 2'h0;
            chan_function_select_ff <= 4'h0;
        end else begin
            if (wr_ctl0) begin
                count_enable_bit_ff <= ce_wdata;
            end
            if (wr_mode) begin
                operating_mode_field_ff <= wdata_i[`MODE_MSB:`MODE_LSB];
            end
            if (wr_ioc2) begin
                event_edge_sel_ff <= wdata_i[`IOC2_EES_MSB:`IOC2_EES_LSB];
            end
            // Trigger edges mean nothing in free-running mode, so they stay 0 there
            if (free_run) begin
                trigger_edge_sel_ff <= 2'h0;
            end else if (wr_ioc2) begin
                trigger_edge_sel_ff <= wdata_i[`IOC2_ETS_MSB:`IOC2_ETS_LSB];
            end
            if (wr_opt0) begin
                chan_function_select_ff <= wdata_i[`OPT0_CCS_MSB:`OPT0_CCS_LSB];
            end
        end
    end

    // Capture edge selects and interrupt mask
    always @(posedge clk_sys_i) begin
        if (srst_i) begin
            cap_edge_ff <= 8'h00;
            irq_mask_ff <= 5'h00;
        end else begin
            if (wr_edge) begin
                cap_edge_ff <= wdata_i[7:0];
            end
            if (wr_mask) begin
                irq_mask_ff <= wdata_i[4:0];
            end
        end
    end

    // Wrap flag; software must clear it, hardware never does
    always @(posedge clk_sys_i) begin
        if (srst_i) begin
            wrap_flag_ff <= 1'b0;
        end else begin
            wrap_flag_ff <= nxt_wrap_flag;
        end
    end

    // Interrupt status, and the level output one cycle behind it
    always @(posedge clk_sys_i) begin
        if (srst_i) begin
            irq_stat_ff <= 5'h00;
            irq_o       <= 1'b0;
        end else begin
            irq_stat_ff <= nxt_irq_stat;
            irq_o       <= nxt_irq;
        end
    end

    // Read mux; unmapped addresses return zero
    always @* begin
        nxt_rdata = `RST_ZERO16;
        case (addr_i)
            `REG_CTL0:     nxt_rdata = {8'h00, count_enable_bit_ff, 7'h00};
            `REG_MODE:     nxt_rdata = {13'h0000, operating_mode_field_ff};
            `REG_IOC2:     nxt_rdata = {12'h000, event_edge_sel_ff,
                                        free_run ? 2'h0 : trigger_edge_sel_ff};
            `REG_OPT0:     nxt_rdata = {8'h00, chan_function_select_ff, 3'h0,
                                        wrap_flag_ff};
            `REG_CHAN0:    nxt_rdata = chan_val_ff[0];
            `REG_CHAN1:    nxt_rdata = chan_val_ff[1];
            `REG_CHAN2:    nxt_rdata = chan_val_ff[2];
            `REG_CHAN3:    nxt_rdata = chan_val_ff[3];
            `REG_COUNT:    nxt_rdata = count_ff;
            `REG_IRQ_STAT: nxt_rdata = {11'h000, irq_stat_ff};
            `REG_IRQ_MASK: nxt_rdata = {11'h000, irq_mask_ff};
            `REG_CAP_EDGE: nxt_rdata = {8'h00, cap_edge_ff};
            default:       nxt_rdata = `RST_ZERO16;
        endcase
    end

    // Read data stands only in the cycle after the strobe
    // Zero outside that slot, so stale data never looks like a fresh read
    always @(posedge clk_sys_i) begin
        if (srst_i) begin
            rdata_o <= `RST_ZERO16;
        end else if (rd_i) begin
            rdata_o <= nxt_rdata;
        end else begin
            rdata_o <= `RST_ZERO16;
        end
    end

endmodule // free_running_timer_capture_compare

/* File: frt_chk.sv */
// Checker for the timer register port, pins and interrupt
// Assumes binding to the timer top; tracks mode, enable and mask from writes
`timescale 1ns/100ps
`include "frt_regs.vh"
module frt_chk (
    input wire        clk_sys_i,
    input wire        srst_i,
    input wire [3:0]  addr_i,
    input wire [15:0] wdata_i,
    input wire        wr_i,
    input wire        rd_i,
    input wire [15:0] rdata_o,
    input wire [3:0]  chan_capture_pin_i,
    input wire [3:0]  chan_output_pin_o,
    input wire        irq_o
);
    logic [2:0] mode_ff;
    logic       en_ff;
    logic [4:0] mask_ff;
    wire run = en_ff && (mode_ff == 3'b101 || mode_ff == 3'b100);
    wire run_free = en_ff && mode_ff == 3'b101;
    always @(posedge clk_sys_i) begin
        if (srst_i) begin
            mode_ff <= 3'h0;
            en_ff   <= 1'b0;
            mask_ff <= 5'h00;
        end else if (wr_i) begin
            if (addr_i == `REG_MODE) mode_ff <= wdata_i[2:0];
            if (addr_i == `REG_CTL0) en_ff <= wdata_i[7];
            if (addr_i == `REG_IRQ_MASK) mask_ff <= wdata_i[4:0];
        end
    end
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (srst_i);
    sequence s_rd_cnt;
        rd_i && addr_i == `REG_COUNT;
    endsequence
    sequence s_stop;
        wr_i && addr_i == `REG_CTL0 && !wdata_i[7];
    endsequence
    property p_rd_once;
        !$past(rd_i) |-> rdata_o == 16'h0000;
    endproperty
    a_rd_once: assert property (p_rd_once) else $error("read data outside slot");
    property p_unmapped;
        rd_i && addr_i > `REG_CAP_EDGE |=> rdata_o == 16'h0000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_cnt_step;
        (s_rd_cnt ##0 run_free) ##1 s_rd_cnt |=> rdata_o - $past(rdata_o) == 16'h0001;
    endproperty
    a_cnt_step: assert property (p_cnt_step) else $error("count step wrong");
    property p_stop_zero;
        s_stop ##1 !wr_i ##1 s_rd_cnt |=> rdata_o == 16'h0000;
    endproperty
    a_stop_zero: assert property (p_stop_zero) else $error("count not cleared");
    property p_start_inv;
        wr_i && addr_i == `REG_CTL0 && wdata_i[7] && !en_ff && mode_ff == 3'b101
            |=> chan_output_pin_o == ~$past(chan_output_pin_o);
    endproperty
    a_start_inv: assert property (p_start_inv) else $error("pins not inverted");
    property p_pins_hold;
        !run && !wr_i |=> $stable(chan_output_pin_o);
    endproperty
    a_pins_hold: assert property (p_pins_hold) else $error("pins moved idle");
    property p_mask_off;
        wr_i && addr_i == `REG_IRQ_MASK && wdata_i[4:0] == 5'h00 |-> ##2 !irq_o;
    endproperty
    a_mask_off: assert property (p_mask_off) else $error("irq ignores mask");
    property p_irq_src;
        $rose(irq_o) |-> $past(mask_ff) != 5'h00;
    endproperty
    a_irq_src: assert property (p_irq_src) else $error("irq with empty mask");
    property p_mask_rd;
        rd_i && addr_i == `REG_IRQ_MASK |=> rdata_o[4:0] == mask_ff;
    endproperty
    a_mask_rd: assert property (p_mask_rd) else $error("mask readback wrong");
endmodule // frt_chk
bind free_running_timer_capture_compare frt_chk u_chk (
    .clk_sys_i(clk_sys_i), .srst_i(srst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o),
    .chan_capture_pin_i(chan_capture_pin_i), .chan_output_pin_o(chan_output_pin_o));

/* File: cap_pin_src.sv */
// Outside world at the capture pins
// Assumes level requests from the bench; one flop of board delay
`timescale 1ns/100ps
module cap_pin_src (
    input  wire  clk_sys_i,
    input  wire  [3:0] level_i,
    output logic [3:0] pin_o
);
    initial pin_o = 4'h0;
    always @(posedge clk_sys_i) pin_o <= level_i;
endmodule // cap_pin_src

/* File: free_running_timer_capture_compare_tb.sv */
// Self-checking bench for the free-running timer
// Assumes 40 MHz clock and the register map of the design header
`timescale 1ns/100ps
`include "frt_regs.vh"
module free_running_timer_capture_compare_tb;
    logic clk_sys_i = 0, srst_i = 1, wr_i = 0, rd_i = 0;
    logic [3:0] addr_i = 0, level = 0, pins_in, pout, pb;
    logic [15:0] wdata_i = 0, rdata_o, d, c, v;
    logic [15:0] mdl [0:15];
    logic irq_o;
    int fail_count = 0, samples_checked = 0, n, m, i;
    integer seed = 39620;
    always #12.5 clk_sys_i = ~clk_sys_i;
    free_running_timer_capture_compare dut (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .chan_capture_pin_i(pins_in), .chan_output_pin_o(pout), .irq_o(irq_o));
    cap_pin_src u_src (.clk_sys_i(clk_sys_i), .level_i(level), .pin_o(pins_in));
    task automatic wr(input [3:0] a, input [15:0] x);
        @(posedge clk_sys_i);
        addr_i <= a;
        wdata_i <= x;
        wr_i <= 1'b1;
        mdl[a] = x;
        @(posedge clk_sys_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input [3:0] a, output [15:0] x);
        @(posedge clk_sys_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_sys_i);
        rd_i <= 1'b0;
        @(negedge clk_sys_i);
        x = rdata_o;
    endtask
    task automatic rd2(input [3:0] a, output [15:0] x, output [15:0] y);
        @(posedge clk_sys_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        x = rdata_o;
        @(posedge clk_sys_i);
        rd_i <= 1'b0;
        @(negedge clk_sys_i);
        y = rdata_o;
    endtask
    task automatic chk(input string nm, input [15:0] e, input [15:0] g);
        samples_checked++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wait_tog(output int k);
        logic p;
        p = pout[0];
        k = 1;
        while (pout[0] === p && k < 200) begin
            @(negedge clk_sys_i);
            k++;
        end
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial begin
        #(25 * 90000);
        fail_count++;
        summarize();
    end
    initial begin
        repeat (12) @(posedge clk_sys_i);
        srst_i <= 1'b0;
        for (i = 0; i < 16; i++) begin
            rd(i[3:0], d);
            chk("reset", 16'h0000, d);
        end
        wr(`REG_CTL0, 16'h0080);
        rd(`REG_COUNT, d);
        chk("count mode 000", 16'h0000, d);
        wr(`REG_CTL0, 16'h0000);
        $display("test reset done");
        v = 16'h0010 + 16'($random(seed) & 15);
        for (m = 0; m < 2; m++) begin
            wr(`REG_MODE, m ? 16'h0004 : 16'h0005);
            wr(`REG_CHAN0, v);
            wr(`REG_IRQ_STAT, 16'h001F);
            wr(`REG_IRQ_MASK, 16'h0001);
            pb = pout;
            wr(`REG_CTL0, 16'h0080);
            @(negedge clk_sys_i);
            if (m == 0) chk("start pins", {12'h0, ~pb}, {12'h0, pout});
            wait_tog(n);
            if (m == 0) chk("match free", v + 16'h0002, 16'(n));
            else chk("match pwm", v + 16'h0001, 16'(n));
            repeat (2) @(negedge clk_sys_i);
            chk("match irq", 16'h0001, {15'h0, irq_o});
            rd(`REG_IRQ_STAT, d);
            chk("match stat", 16'h0001, {15'h0, d[0]});
            wr(`REG_CTL0, 16'h0000);
        end
        $display("test compare done");
        wr(`REG_MODE, 16'h0005);
        wr(`REG_IOC2, 16'h000F);
        rd(`REG_IOC2, d);
        chk("ioc2", 16'h000C, d);
        wr(`REG_OPT0, 16'h0020);
        wr(`REG_CAP_EDGE, 16'h0004);
        wr(`REG_IRQ_STAT, 16'h001F);
        wr(`REG_IRQ_MASK, 16'h0002);
        wr(`REG_CTL0, 16'h0080);
        rd(`REG_COUNT, d);
        wr(`REG_CHAN0, d + 16'h0020);
        @(negedge clk_sys_i);
        wait_tog(n);
        chk("live compare", 16'h001F, 16'(n));
        rd(`REG_COUNT, d);
        @(posedge clk_sys_i);
        level <= 4'h2;
        repeat (12) @(posedge clk_sys_i);
        rd(`REG_CHAN1, c);
        chk("capture", 16'h0001, 16'(c - d >= 5 && c - d <= 7));
        rd(`REG_IRQ_STAT, d);
        chk("capture stat", 16'h0001, {15'h0, d[1]});
        chk("capture irq", 16'h0001, {15'h0, irq_o});
        rd2(`REG_COUNT, d, c);
        chk("count step", d + 16'h0001, c);
        $display("test capture done");
        wr(`REG_IRQ_STAT, 16'h001F);
        wr(`REG_IRQ_MASK, 16'h0010);
        n = 0;
        while (irq_o !== 1'b1 && n < 70000) begin
            @(negedge clk_sys_i);
            n++;
        end
        chk("wrap irq", 16'h0001, {15'h0, irq_o});
        rd(`REG_COUNT, d);
        chk("wrapped", 16'h0001, 16'(d < 16'h0010));
        rd(`REG_OPT0, d);
        chk("wrap flag", 16'h0001, {15'h0, d[0]});
        wr(`REG_OPT0, 16'h0021);
        rd(`REG_OPT0, d);
        chk("flag held", 16'h0001, {15'h0, d[0]});
        wr(`REG_OPT0, 16'h0020);
        rd(`REG_OPT0, d);
        chk("flag cleared", 16'h0000, {15'h0, d[0]});
        rd(`REG_IRQ_MASK, d);
        chk("mask", mdl[`REG_IRQ_MASK], d);
        wr(`REG_IRQ_MASK, 16'h0000);
        repeat (2) @(negedge clk_sys_i);
        chk("irq masked", 16'h0000, {15'h0, irq_o});
        wr(`REG_CTL0, 16'h0000);
        rd(`REG_COUNT, d);
        chk("stopped", 16'h0000, d);
        $display("test wrap done");
        summarize();
    end
endmodule // free_running_timer_capture_compare_tb
